// ===== bench/tb.sv
/*
 * Self-checking bench for the uncorrectable error status and mask block.
 * Assumes the registered one-cycle read answer and event timing of the core.
 */
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uesm_pkg::*;

    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic flr_n = 1'b1;
    logic gcr_n = 1'b1;
    logic fire = 1'b0;
    logic [3:0] idx = 4'h0;
    uesm_cfg_req_t req = '0;
    uesm_err_t ev;
    uesm_err_t rep;
    logic [31:0] rdata;
    logic hdr;
    logic upd;
    logic [4:0] ptr;
    logic [31:0] exp_st;
    int pos [10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
    int n_errors = 0;
    int comparisons = 0;

    always #50 core_clk = ~core_clk;

    uesm_err_src i_uesm_err_src (.fire(fire), .idx(idx), .ev(ev));

    uesm_core i_uesm_core (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .fundamental_link_reset_n(flr_n), .global_chip_reset_n(gcr_n), .cfg_req(req),
        .cfg_rdata_q(rdata), .err_event(ev), .err_report_q(rep), .hdr_log_load_q(hdr),
        .first_err_update_q(upd), .first_err_ptr_q(ptr));

    task automatic cfg_wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge core_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
        @(negedge core_clk);
        req = '0;
    endtask

    task automatic cfg_rd(input logic [11:0] a, input logic [31:0] e);
        @(negedge core_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0};
        @(negedge core_clk);
        req = '0;
        `CHK(rdata, e)
    endtask

    task automatic cfg_wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        @(negedge core_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, be: 4'hf, wdata: d};
        @(negedge core_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0};
        @(negedge core_clk);
        req = '0;
        `CHK(rdata, e)
    endtask

    task automatic hit(input int i, input logic [9:0] rep_e, input logic hdr_e);
        @(negedge core_clk);
        fire = 1'b1;
        idx = i[3:0];
        @(negedge core_clk);
        fire = 1'b0;
        `CHK(rep, rep_e)
        `CHK(hdr, hdr_e)
        `CHK(upd, hdr_e)
    endtask

    task automatic tally_and_finish();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        cfg_rd(12'h104, 32'h0);
        cfg_rd(12'h108, 32'h0);
        cfg_rd(12'h10c, 32'h0);
        cfg_wr_rd(12'h108, 32'hffffffff, 32'h001ff010);
        for (int i = 0; i < 10; i++) hit(i, 10'h0, 1'b0);
        cfg_rd(12'h104, 32'h0);
        cfg_wr(12'h108, 4'h2, 32'h0);
        cfg_rd(12'h108, 32'h001f0010);
        cfg_wr(12'h108, 4'hf, 32'h0);
        exp_st = 32'h0;
        for (int i = 0; i < 10; i++) begin
            hit(i, 10'h200 >> i, i == 0);
            exp_st[pos[i]] = 1'b1;
            cfg_rd(12'h104, exp_st);
        end
        `CHK(ptr, 5'd20)
        hit(0, 10'h200, 1'b0);
        cfg_rd(12'h104, 32'h001ff010);
        cfg_wr(12'h104, 4'hf, 32'h0);
        cfg_rd(12'h104, 32'h001ff010);
        cfg_wr(12'h104, 4'h1, 32'hffffffff);
        cfg_rd(12'h104, 32'h001ff000);
        cfg_wr(12'h104, 4'hf, 32'hffffffff);
        cfg_rd(12'h104, 32'h0);
        for (int p = 0; p < 2; p++) begin
            cfg_wr(12'h108, 4'hf, 32'h00100000);
            hit(8, 10'h002, 1'b1);
            flr_n = (p != 0);
            gcr_n = (p == 0);
            repeat (6) @(negedge core_clk);
            flr_n = 1'b1;
            gcr_n = 1'b1;
            repeat (6) @(negedge core_clk);
            cfg_rd(12'h108, 32'h0);
            cfg_rd(12'h104, 32'h0);
        end
        @(negedge core_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: 12'h104, be: 4'hf, wdata: 32'hffffffff};
        fire = 1'b1;
        idx = 4'h8;
        @(negedge core_clk);
        req = '0;
        fire = 1'b0;
        cfg_rd(12'h104, 32'h00001000);
        ce = 1'b0;
        fire = 1'b1;
        idx = 4'h0;
        @(negedge core_clk);
        fire = 1'b0;
        @(negedge core_clk);
        ce = 1'b1;
        cfg_rd(12'h104, 32'h00001000);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        cfg_rd(12'h104, 32'h0);
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire

// ===== bench/uesm_err_src.sv
/*
 * Error source model for the link logic that detects uncorrectable errors.
 * Assumes the bench holds fire for exactly one cycle per event.
 */
`default_nettype none

module uesm_err_src (
    input wire logic fire,
    input wire logic [3:0] idx,
    output uesm_pkg::uesm_err_t ev
);
    timeunit 1ns;
    timeprecision 1ns;
    import uesm_pkg::*;

    // One class per event, index 0 being the highest bit position.
    assign ev = fire ? uesm_err_t'(10'h200 >> idx) : uesm_err_t'(10'h000);
endmodule // uesm_err_src

`default_nettype wire

// ===== logic/uesm_core.sv
/*
 * Uncorrectable error status and mask registers of the primary link.
 * Assumes error events are one-cycle pulses from logic on core_clk, and the
 * configuration port gives single-cycle read and write strobes.
 */
`include "uesm_defs.svh"
`default_nettype none

// Contract
// - Reserved status bits always read zero.
// - Access-control violation status reads zero.
// - Unsupported request sets bit 20.
// - End-to-end CRC error sets bit 19.
// - Malformed packet sets bit 18.
// - Receiver credit overflow sets bit 17.
// - Unexpected completion sets bit 16.
// - Own completer abort sets bit 15.
// - Completion timeout sets bit 14.
// - Flow control protocol error sets bit 13.
// - Poisoned packet sets bit 12.
// - Surprise-down status reads zero.
// - Link layer protocol error sets bit 4.
// - Status clears only on written one.
// - Masked errors never set status.
// - Masked errors send no error message.
// - Masked errors load no header log.
// - Masked errors leave first-error pointer.
// - Mask bits 20:12, 4 writable, reset zero.
// - Access-control mask bit hard-wired zero.
// - Surprise-down mask bit hard-wired zero.
// - Reserved mask bits read zero.
// - Fundamental/global/power-on reset only, not hot.
module uesm_core (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic fundamental_link_reset_n,
    input wire logic global_chip_reset_n,
    input wire uesm_pkg::uesm_cfg_req_t cfg_req,
    output logic [31:0] cfg_rdata_q,
    input wire uesm_pkg::uesm_err_t err_event,
    output uesm_pkg::uesm_err_t err_report_q,
    output logic hdr_log_load_q,
    output logic first_err_update_q,
    output logic [4:0] first_err_ptr_q
);
    import uesm_pkg::*;

    localparam logic [31:0] IMPL = `UESM_IMPL_BITS;

    // Status bit position of each event class, indexed like the event vector (lowest class first).
    localparam int CLS_POS [10] = '{`UESM_POS_LINK_PROTOCOL, `UESM_POS_POISONED_PACKET,
        `UESM_POS_CREDIT_PROTOCOL, `UESM_POS_COMPLETION_TIMER_EXPIRED, `UESM_POS_COMPLETER_ABORT,
        `UESM_POS_UNEXPECTED_COMPLETION, `UESM_POS_RECEIVER_OVERFLOW, `UESM_POS_MALFORMED_PACKET,
        `UESM_POS_END_TO_END_CRC, `UESM_POS_UNSUPPORTED_REQUEST};

    logic [1:0] rst_lvl_q;
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] mask_q;
    logic [31:0] mask_d;

    uesm_pin_sync #(
        .WIDTH(2),
        .INIT(2'h3)
    ) u_rst_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin_in({fundamental_link_reset_n, global_chip_reset_n}),
        .level_q(rst_lvl_q)
    );

    // Hot reset is deliberately not an input: these bits survive it.
    wire sticky_clr = ~(&rst_lvl_q);

    wire [9:0] ev_bits = err_event;
    wire [31:0] ev_vec = {11'h000, ev_bits[9:1], 7'h00, ev_bits[0], 4'h0};
    wire [9:0] class_hit = ev_bits & ~{mask_q[20:12], mask_q[4]};
    wire [31:0] unmasked_ev = ev_vec & ~mask_q & IMPL;
    wire any_unmasked = |unmasked_ev;
    wire [31:0] be_bits = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
    wire [31:0] wr_bits = cfg_req.wdata & be_bits & IMPL;
    wire wr_status = cfg_req.wr && (cfg_req.addr == `UESM_STATUS_OFS);
    wire wr_mask = cfg_req.wr && (cfg_req.addr == `UESM_MASK_OFS);
    wire rd_status = cfg_req.rd && (cfg_req.addr == `UESM_STATUS_OFS);
    wire rd_mask = cfg_req.rd && (cfg_req.addr == `UESM_MASK_OFS);
    wire [31:0] w1c_vec = wr_status ? wr_bits : 32'h00000000;
    wire first_error = any_unmasked && ((status_q & ~mask_q) == 32'h00000000);

    // Per-bit flag and mask cells; a new event in the clearing cycle survives the clear.
    genvar b;
    generate
        for (b = 0; b < 32; b++) begin : g_cell
            if (IMPL[b]) begin : g_impl
                assign status_d[b] = unmasked_ev[b] | (status_q[b] & ~w1c_vec[b]);
                assign mask_d[b] = (wr_mask && be_bits[b]) ? wr_bits[b] : mask_q[b];
            end else begin : g_rsvd
                assign status_d[b] = 1'b0;
                assign mask_d[b] = 1'b0;
            end
        end
    endgenerate

    wire [31:0] rdata_d = rd_status ? status_q : (rd_mask ? mask_q : `UESM_READ_IDLE);

    // Highest-numbered unmasked class wins the pointer.
    function automatic logic [4:0] top_bit(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int k = 0; k < 32; k++) begin
            if (v[k]) begin
                r = 5'(k);
            end
        end
        return r;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `UESM_STATUS_RESET;
            mask_q <= `UESM_MASK_RESET;
        end else if (ce) begin
            if (sticky_clr) begin
                status_q <= `UESM_STATUS_RESET;
                mask_q <= `UESM_MASK_RESET;
            end else begin
                status_q <= status_d;
                mask_q <= mask_d;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata_q <= `UESM_READ_IDLE;
            err_report_q <= '0;
            hdr_log_load_q <= 1'b0;
            first_err_update_q <= 1'b0;
            first_err_ptr_q <= 5'h00;
        end else if (ce) begin
            cfg_rdata_q <= rdata_d;
            err_report_q <= class_hit;
            hdr_log_load_q <= first_error;
            first_err_update_q <= first_error;
            if (first_error) begin
                first_err_ptr_q <= top_bit(unmasked_ev);
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_mask_write;
        ce && wr_mask && !sticky_clr && (cfg_req.be == 4'hf);
    endsequence

    sequence s_mask_read;
        ce && rd_mask;
    endsequence

    sequence s_flr_low;
        ce && !fundamental_link_reset_n;
    endsequence

    sequence s_gcr_low;
        ce && !global_chip_reset_n;
    endsequence

    sequence s_status_w1c_all;
        ce && wr_status && !sticky_clr && (cfg_req.be == 4'hf) && (cfg_req.wdata == 32'hffffffff);
    endsequence

    AST_STATUS_RSVD_ZERO: assert property ((ce && rd_status) |=> ((cfg_rdata_q & ~IMPL) == 32'h0))
        else $error("Status read shows a reserved or unsupported bit set.");

    AST_EVENT_SETS_FLAG: assert property ((ce && !sticky_clr && any_unmasked)
        |=> ((status_q & $past(unmasked_ev)) == $past(unmasked_ev)))
        else $error("Unmasked error did not set its status flag.");

    AST_MASKED_NO_SET: assert property ((ce && !sticky_clr)
        |=> (((status_q & ~$past(status_q)) & ~$past(ev_vec & ~mask_q)) == 32'h0))
        else $error("Status flag rose without an unmasked error.");

    AST_ONLY_W1C_CLEARS: assert property ((ce && !sticky_clr)
        |=> (((~status_q & $past(status_q)) & ~$past(w1c_vec)) == 32'h0))
        else $error("Status flag cleared without a written one.");

    AST_REPORT_MASKED: assert property ((ce && !sticky_clr)
        |=> (err_report_q == $past(ev_bits & ~{mask_q[20:12], mask_q[4]})))
        else $error("Error message request disagrees with mask.");

    AST_HDR_NEEDS_UNMASKED: assert property ($rose(hdr_log_load_q) |-> $past(any_unmasked))
        else $error("Header log load without an unmasked error.");

    AST_PTR_HOLDS: assert property ((ce && !any_unmasked) |=> (first_err_ptr_q == $past(first_err_ptr_q)))
        else $error("First-error pointer moved without an unmasked error.");

    AST_MASK_HARDWIRED: assert property ((mask_q & ~IMPL) == 32'h0)
        else $error("Hard-wired or reserved mask bit is set.");

    AST_MASK_WRITE_READ: assert property ((s_mask_write ##1 s_mask_read)
        |=> (cfg_rdata_q == ($past(cfg_req.wdata, 2) & IMPL)))
        else $error("Mask read does not return the written value.");

    AST_STICKY_RESET: assert property ((ce && sticky_clr) |=> (status_q == 32'h0 && mask_q == 32'h0))
        else $error("Fundamental or global reset did not clear the registers.");

    // Each unmasked class sets its own flag, and a class whose mask bit is set requests no message.
    genvar c;
    generate
        for (c = 0; c < 10; c++) begin : g_cls
            AST_CLS_SETS: assert property ((ce && !sticky_clr && class_hit[c])
                |=> status_q[CLS_POS[c]])
                else $error("Unmasked error class did not set its status flag.");

            AST_CLS_MASKED_QUIET: assert property ((ce && ev_bits[c] && mask_q[CLS_POS[c]])
                |=> !err_report_q[c])
                else $error("Masked error class still requested a message.");
        end
    endgenerate

    AST_STATUS_READ: assert property ((ce && rd_status) |=> (cfg_rdata_q == $past(status_q)))
        else $error("Status read does not return the held flags.");

    AST_MASK_READ_RSVD: assert property ((ce && rd_mask) |=> ((cfg_rdata_q & ~IMPL) == 32'h0))
        else $error("Mask read shows a reserved bit set.");

    AST_RDATA_IDLE: assert property ((ce && !cfg_req.rd) |=> (cfg_rdata_q == 32'h0))
        else $error("Read data not idle after a cycle without a read.");

    AST_STATUS_RSVD_HELD: assert property ((status_q & ~IMPL) == 32'h0)
        else $error("Reserved status bit is set.");

    AST_ACS_STATUS_ZERO: assert property (!status_q[`UESM_POS_ACCESS_CONTROL_VIOLATION])
        else $error("Access-control violation flag is set.");

    AST_SD_STATUS_ZERO: assert property (!status_q[`UESM_POS_SURPRISE_DOWN])
        else $error("Surprise-down flag is set.");

    AST_ACS_MASK_ZERO: assert property (!mask_q[`UESM_POS_ACCESS_CONTROL_VIOLATION])
        else $error("Access-control violation mask bit is set.");

    AST_SD_MASK_ZERO: assert property (!mask_q[`UESM_POS_SURPRISE_DOWN])
        else $error("Surprise-down mask bit is set.");

    AST_STATUS_STICKY: assert property ((ce && !sticky_clr && !wr_status)
        |=> ((status_q & $past(status_q)) == $past(status_q)))
        else $error("Status flag dropped without a status write.");

    AST_W1C_ALL_CLEARS: assert property (s_status_w1c_all
        |=> ((status_q & ~$past(unmasked_ev)) == 32'h0))
        else $error("Writing ones did not clear the status flags.");

    AST_MASK_HOLDS: assert property ((ce && !sticky_clr && !wr_mask) |=> (mask_q == $past(mask_q)))
        else $error("Mask changed without a mask write.");

    AST_HDR_QUIET_MASKED: assert property ((ce && !any_unmasked) |=> !hdr_log_load_q)
        else $error("Header log load without an unmasked error.");

    AST_UPD_QUIET_MASKED: assert property ((ce && !any_unmasked) |=> !first_err_update_q)
        else $error("First-error update without an unmasked error.");

    AST_FIRST_ERR_PULSE: assert property ((ce && first_error) |=> (hdr_log_load_q && first_err_update_q))
        else $error("First unmasked error did not load the header log.");

    AST_NO_SECOND_HDR: assert property ((ce && ((status_q & ~mask_q) != 32'h0)) |=> !hdr_log_load_q)
        else $error("Header log reloaded while an earlier error is pending.");

    AST_PTR_IMPL: assert property ((ce && first_error) |=> IMPL[first_err_ptr_q])
        else $error("First-error pointer names an unimplemented bit.");

    AST_FROZEN_CE: assert property (!ce |=> ($stable(status_q) && $stable(mask_q)))
        else $error("Registers changed while the clock enable was low.");

    AST_FLR_CLEARS: assert property ((s_flr_low [*4]) |=> sticky_clr)
        else $error("Fundamental link reset was not taken in time.");

    AST_GCR_CLEARS: assert property ((s_gcr_low [*4]) |=> sticky_clr)
        else $error("Global reset was not taken in time.");

endmodule : uesm_core

`default_nettype wire

// ===== logic/uesm_defs.svh
/*
 * Offsets, field positions and reset values of the uncorrectable error
 * status and mask registers.
 * Assumes a 12-bit extended configuration byte address and 32-bit data.
 */
`ifndef UESM_DEFS_SVH
`define UESM_DEFS_SVH

`define UESM_ADDR_W 12
`define UESM_STATUS_OFS 12'h104
`define UESM_MASK_OFS 12'h108

`define UESM_POS_UNSUPPORTED_REQUEST 20
`define UESM_POS_END_TO_END_CRC 19
`define UESM_POS_MALFORMED_PACKET 18
`define UESM_POS_RECEIVER_OVERFLOW 17
`define UESM_POS_UNEXPECTED_COMPLETION 16
`define UESM_POS_COMPLETER_ABORT 15
`define UESM_POS_COMPLETION_TIMER_EXPIRED 14
`define UESM_POS_CREDIT_PROTOCOL 13
`define UESM_POS_POISONED_PACKET 12
`define UESM_POS_SURPRISE_DOWN 5
`define UESM_POS_LINK_PROTOCOL 4
`define UESM_POS_ACCESS_CONTROL_VIOLATION 21

`define UESM_IMPL_BITS 32'h001ff010
`define UESM_STATUS_RESET 32'h00000000
`define UESM_MASK_RESET 32'h00000000
`define UESM_READ_IDLE 32'h00000000

`define UESM_SYNC_STAGES 3

`endif

// ===== logic/uesm_pin_sync.sv
/*
 * Three-stage synchroniser for pin-level inputs with agreement filter.
 * Assumes inputs are asynchronous levels; output changes only once the
 * second and third stages agree.
 */
`include "uesm_defs.svh"
`default_nettype none

module uesm_pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic [`UESM_SYNC_STAGES-1:0] stage_q;
            logic lvl_q;
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_q <= {`UESM_SYNC_STAGES{INIT[i]}};
                    lvl_q <= INIT[i];
                end else if (ce) begin
                    stage_q <= {stage_q[`UESM_SYNC_STAGES-2:0], pin_in[i]};
                    if (stage_q[1] == stage_q[2]) begin
                        lvl_q <= stage_q[2];
                    end
                end
            end
            assign level_q[i] = lvl_q;
        end
    endgenerate

endmodule : uesm_pin_sync

`default_nettype wire

// ===== logic/uesm_pkg.sv
/*
 * Types shared by the uncorrectable error status and mask block.
 * Assumes nothing beyond the definitions header.
 */
`default_nettype none

package uesm_pkg;

    // Error events, one per implemented class, highest bit position first.
    typedef struct packed {
        logic unsupported_request_flag;
        logic end_to_end_crc_flag;
        logic malformed_packet_flag;
        logic receiver_overflow_flag;
        logic unexpected_completion_flag;
        logic completer_abort_flag;
        logic completion_timer_expired_flag;
        logic credit_protocol_flag;
        logic poisoned_packet_flag;
        logic link_protocol_flag;
    } uesm_err_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } uesm_cfg_req_t;

endpackage : uesm_pkg

`default_nettype wire
